// *** design/pmw_defs.svh ***
`ifndef PMW_DEFS_SVH
`define PMW_DEFS_SVH

// core clock rate
`define CLK_MHZ 200
// start-up monitoring window and its prescaler tick
`define MONITOR_TIMEOUT_US 80000
`define MONITOR_TICK_NS 1000
// reset line hold after an internal reset source ends
`define RESET_HOLD_NS 1250000
// least dominant time before a bus rising edge counts as a wake
`define DOMINANT_MIN_NS 30000
// length of the event request pulse
`define EVENT_PULSE_NS 100
// reset values
`define IRQ_VEC_RESET 8'h00
`define COUNT_ZERO 32'h00000000
`define COUNT_ONE 32'h00000001

`endif

// *** design/pmw_pkg.sv ***
package pmw_pkg;

	typedef enum logic [2:0] {
		MODE_RESET = 3'b000,
		MODE_NORM_REQ = 3'b001,
		MODE_NORMAL = 3'b010,
		MODE_STOP = 3'b011,
		MODE_SLEEP = 3'b100
	} mode_t;

	// flag and mask layout, one bit per source
	typedef struct packed {
		logic wake_input;
		logic hall_input;
		logic bus_wake;
		logic reserved;
		logic overtemp;
		logic low_supply;
		logic high_supply;
		logic stage_fail;
	} irq_vec_t;

	// supply and condition inputs
	typedef struct packed {
		logic low_supply;
		logic high_supply;
		logic overtemp;
		logic stage_fail;
	} cond_t;

	// steering of the surrounding power and bus blocks
	typedef struct packed {
		logic regulator_on;
		logic regulator_limited;
		logic power_stage_en;
		logic lin_enable;
		logic lin_wake_only;
		logic monitor_active;
	} power_ctl_t;

endpackage : pmw_pkg

// *** design/power_mode_wake_irq_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pmw_defs.svh"

module power_mode_wake_irq_ctrl #(
	parameter int unsigned TICK_CYCLES = (`MONITOR_TICK_NS * `CLK_MHZ) / 1000,
	parameter int unsigned MONITOR_TICKS = (`MONITOR_TIMEOUT_US * 1000) / `MONITOR_TICK_NS,
	parameter int unsigned RESET_HOLD_CYCLES = (`RESET_HOLD_NS * `CLK_MHZ + 999) / 1000,
	parameter int unsigned DOMINANT_CYCLES = (`DOMINANT_MIN_NS * `CLK_MHZ + 999) / 1000
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// system control bits
	input wire logic STOP_REQ,
	input wire logic SLEEP_REQ,
	input wire logic POWER_STAGE_ON_ACK,
	input wire logic FACTORY_TEST_STRAP,
	// flag clear and mask writes
	input wire logic FLAG_CLR_WR,
	input wire pmw_pkg::irq_vec_t FLAG_CLR_DATA,
	input wire logic MASK_WR,
	input wire pmw_pkg::irq_vec_t MASK_DATA,
	input wire logic RST_STATUS_CLR,
	// event sources
	input wire logic WAKE_INPUT,
	input wire logic LIN_RX,
	input wire logic WAKE_LEVEL_FLAG,
	input wire logic HALL_LEVEL_FLAG,
	input wire logic HALL_IRQ_CAPABLE,
	input wire pmw_pkg::cond_t COND,
	input wire logic INT_RESET_EVENT,
	// outputs toward MCU and power blocks
	output logic RESET_LINE_N,
	output logic EVENT_REQUEST_N,
	output pmw_pkg::mode_t MODE,
	output pmw_pkg::power_ctl_t POWER_CTL,
	output pmw_pkg::irq_vec_t FLAGS,
	output pmw_pkg::irq_vec_t MASK,
	output logic WAKE_INPUT_WAKE_FLAG,
	output logic BUS_WAKE_RESET_FLAG
);

	localparam int unsigned PULSE_CYCLES = (`EVENT_PULSE_NS * `CLK_MHZ + 999) / 1000;

	function automatic logic [7:0] set_wins(input logic [7:0] cur, input logic [7:0] set,
			input logic [7:0] clr);
		set_wins = set | (cur & ~clr);
	endfunction : set_wins

	function automatic logic changed(input logic now, input logic prev);
		changed = now ^ prev;
	endfunction : changed

	pmw_pkg::mode_t state;
	pmw_pkg::mode_t next_state;
	logic [31:0] hold_cnt;
	logic [31:0] pre_cnt;
	logic [31:0] tick_cnt;
	logic [31:0] dom_cnt;
	logic [31:0] pulse_cnt;
	logic wake_in_prev;
	logic lin_prev;
	logic wake_lvl_prev;
	logic hall_lvl_prev;
	logic [7:0] pend_prev;
	logic active;
	logic lin_wake;
	logic wake_in_edge;
	logic stop_wake;
	logic sleep_wake;
	logic mon_done;
	logic hold_done;
	pmw_pkg::irq_vec_t set_vec;
	pmw_pkg::irq_vec_t clr_vec;
	logic [7:0] pend;

	assign active = (state == pmw_pkg::MODE_NORM_REQ) || (state == pmw_pkg::MODE_NORMAL);
	assign wake_in_edge = changed(WAKE_INPUT, wake_in_prev);
	// rising bus edge after a long enough dominant phase
	assign lin_wake = LIN_RX && !lin_prev && (dom_cnt >= DOMINANT_CYCLES);
	assign stop_wake = (MASK.bus_wake && lin_wake) || (MASK.wake_input && wake_in_edge);
	assign sleep_wake = lin_wake || wake_in_edge;
	assign mon_done = tick_cnt >= MONITOR_TICKS;
	assign hold_done = hold_cnt >= (RESET_HOLD_CYCLES - `COUNT_ONE);
	assign pend = FLAGS & MASK;

	always_comb begin
		next_state = state;
		case (state)
			pmw_pkg::MODE_RESET: begin
				if (!INT_RESET_EVENT && hold_done) begin
					next_state = pmw_pkg::MODE_NORM_REQ;
				end
			end
			pmw_pkg::MODE_NORM_REQ: begin
				if (INT_RESET_EVENT) begin
					next_state = pmw_pkg::MODE_RESET;
				end else if (POWER_STAGE_ON_ACK) begin
					next_state = pmw_pkg::MODE_NORMAL;
				end else if (mon_done && !FACTORY_TEST_STRAP) begin
					next_state = pmw_pkg::MODE_SLEEP;
				end
			end
			pmw_pkg::MODE_NORMAL: begin
				if (INT_RESET_EVENT) begin
					next_state = pmw_pkg::MODE_RESET;
				end else if (SLEEP_REQ) begin
					next_state = pmw_pkg::MODE_SLEEP;
				end else if (STOP_REQ) begin
					next_state = pmw_pkg::MODE_STOP;
				end
			end
			pmw_pkg::MODE_STOP: begin
				if (INT_RESET_EVENT) begin
					next_state = pmw_pkg::MODE_RESET;
				end else if (stop_wake) begin
					next_state = pmw_pkg::MODE_NORM_REQ;
				end
			end
			pmw_pkg::MODE_SLEEP: begin
				if (sleep_wake) begin
					next_state = pmw_pkg::MODE_RESET;
				end
			end
			default: begin
				next_state = pmw_pkg::MODE_RESET;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			state <= pmw_pkg::MODE_RESET;
		end else begin
			state <= next_state;
		end
	end

	// reset line hold, restarted while an internal source is active
	always_ff @(posedge CORE_CLK) begin
		if (RST || state != pmw_pkg::MODE_RESET || INT_RESET_EVENT) begin
			hold_cnt <= `COUNT_ZERO;
		end else if (!hold_done) begin
			hold_cnt <= hold_cnt + `COUNT_ONE;
		end
	end

	// start-up monitor: runs from release of reset line until ack
	always_ff @(posedge CORE_CLK) begin
		if (RST || state != pmw_pkg::MODE_NORM_REQ) begin
			pre_cnt <= `COUNT_ZERO;
			tick_cnt <= `COUNT_ZERO;
		end else if (pre_cnt >= (TICK_CYCLES - `COUNT_ONE)) begin
			pre_cnt <= `COUNT_ZERO;
			if (!mon_done) begin
				tick_cnt <= tick_cnt + `COUNT_ONE;
			end
		end else begin
			pre_cnt <= pre_cnt + `COUNT_ONE;
		end
	end

	// dominant phase length, saturating
	always_ff @(posedge CORE_CLK) begin
		if (RST || LIN_RX) begin
			dom_cnt <= `COUNT_ZERO;
		end else if (dom_cnt < DOMINANT_CYCLES) begin
			dom_cnt <= dom_cnt + `COUNT_ONE;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			wake_in_prev <= 1'b0;
			lin_prev <= 1'b1;
			wake_lvl_prev <= 1'b0;
			hall_lvl_prev <= 1'b0;
		end else begin
			wake_in_prev <= WAKE_INPUT;
			lin_prev <= LIN_RX;
			wake_lvl_prev <= WAKE_LEVEL_FLAG;
			hall_lvl_prev <= HALL_LEVEL_FLAG;
		end
	end

	always_comb begin
		set_vec = `IRQ_VEC_RESET;
		// condition detectors only work in run states
		set_vec.low_supply = active && COND.low_supply;
		set_vec.high_supply = active && COND.high_supply;
		set_vec.overtemp = active && COND.overtemp;
		set_vec.stage_fail = active && COND.stage_fail;
		set_vec.hall_input = active && HALL_IRQ_CAPABLE
			&& changed(HALL_LEVEL_FLAG, hall_lvl_prev);
		set_vec.wake_input = (active && changed(WAKE_LEVEL_FLAG, wake_lvl_prev))
			|| (state == pmw_pkg::MODE_STOP && MASK.wake_input && wake_in_edge);
		set_vec.bus_wake = state == pmw_pkg::MODE_STOP && MASK.bus_wake && lin_wake;
		clr_vec = FLAG_CLR_WR ? FLAG_CLR_DATA : `IRQ_VEC_RESET;
		// a clear cannot drop a supply or overtemp condition that is still present
		clr_vec.low_supply = clr_vec.low_supply && !COND.low_supply;
		clr_vec.high_supply = clr_vec.high_supply && !COND.high_supply;
		clr_vec.overtemp = clr_vec.overtemp && !COND.overtemp;
	end

	// flags and mask are cleared by any reset, including the reset state
	always_ff @(posedge CORE_CLK) begin
		if (RST || state == pmw_pkg::MODE_RESET) begin
			FLAGS <= `IRQ_VEC_RESET;
		end else begin
			FLAGS <= set_wins(FLAGS, set_vec, clr_vec);
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (RST || state == pmw_pkg::MODE_RESET) begin
			MASK <= `IRQ_VEC_RESET;
		end else if (MASK_WR) begin
			MASK <= MASK_DATA;
			MASK.reserved <= 1'b0;
		end
	end

	// wake-from-sleep cause, survives the reset it causes
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			WAKE_INPUT_WAKE_FLAG <= 1'b0;
			BUS_WAKE_RESET_FLAG <= 1'b0;
		end else begin
			WAKE_INPUT_WAKE_FLAG <= (state == pmw_pkg::MODE_SLEEP && wake_in_edge)
				|| (WAKE_INPUT_WAKE_FLAG && !RST_STATUS_CLR);
			BUS_WAKE_RESET_FLAG <= (state == pmw_pkg::MODE_SLEEP && lin_wake)
				|| (BUS_WAKE_RESET_FLAG && !RST_STATUS_CLR);
		end
	end

	// request pulse on any newly pending enabled flag
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			pend_prev <= `IRQ_VEC_RESET;
			pulse_cnt <= `COUNT_ZERO;
			EVENT_REQUEST_N <= 1'b1;
		end else begin
			pend_prev <= pend;
			if (|(pend & ~pend_prev)) begin
				pulse_cnt <= PULSE_CYCLES;
			end else if (pulse_cnt != `COUNT_ZERO) begin
				pulse_cnt <= pulse_cnt - `COUNT_ONE;
			end
			EVENT_REQUEST_N <= !((|(pend & ~pend_prev)) || pulse_cnt > `COUNT_ONE);
		end
	end

	// registered mode outputs, one cycle behind the state
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			MODE <= pmw_pkg::MODE_RESET;
			RESET_LINE_N <= 1'b0;
			POWER_CTL <= '0;
		end else begin
			MODE <= state;
			RESET_LINE_N <= state != pmw_pkg::MODE_RESET && state != pmw_pkg::MODE_SLEEP;
			POWER_CTL.regulator_on <= state != pmw_pkg::MODE_SLEEP;
			POWER_CTL.regulator_limited <= state == pmw_pkg::MODE_STOP;
			POWER_CTL.power_stage_en <= state == pmw_pkg::MODE_NORMAL;
			POWER_CTL.lin_enable <= state == pmw_pkg::MODE_NORMAL;
			POWER_CTL.lin_wake_only <= state == pmw_pkg::MODE_STOP
				|| state == pmw_pkg::MODE_SLEEP;
			POWER_CTL.monitor_active <= state == pmw_pkg::MODE_NORM_REQ && !FACTORY_TEST_STRAP;
		end
	end

endmodule : power_mode_wake_irq_ctrl

`default_nettype wire

// *** verif/mcu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic irq_n,
	input wire logic ack_en,
	output logic ack,
	output int pulses
);
	int up;
	initial begin
		ack = 1'b0;
		pulses = 0;
		up = 0;
	end
	// ack only once running a few cycles after reset, held so a stop wake is acked too
	always @(negedge clk) begin
		up = reset_n ? up + 1 : 0;
		ack = ack_en && up > 3;
	end
	always @(negedge irq_n) pulses++;
endmodule : mcu_model
`default_nettype wire

// *** verif/pmw_chk_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module pmw_chk (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic STOP_REQ,
	input wire logic SLEEP_REQ,
	input wire logic FACTORY_TEST_STRAP,
	input wire logic FLAG_CLR_WR,
	input wire pmw_pkg::irq_vec_t FLAG_CLR_DATA,
	input wire pmw_pkg::cond_t COND,
	input wire logic RESET_LINE_N,
	input wire logic EVENT_REQUEST_N,
	input wire pmw_pkg::mode_t MODE,
	input wire pmw_pkg::power_ctl_t POWER_CTL,
	input wire pmw_pkg::irq_vec_t FLAGS,
	input wire pmw_pkg::irq_vec_t MASK
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	wire logic pend = |(FLAGS & MASK);
	sequence s_low8;
		!EVENT_REQUEST_N [*8];
	endsequence
	sequence s_wake;
		MODE == pmw_pkg::MODE_RESET || |(FLAGS & MASK & 8'hA0);
	endsequence
	a_sleep_outputs: assert property (MODE == pmw_pkg::MODE_SLEEP |-> !RESET_LINE_N && !POWER_CTL.regulator_on)
		else $error("sleep outputs wrong");
	a_lowpower_off: assert property (
		MODE inside {pmw_pkg::MODE_STOP, pmw_pkg::MODE_SLEEP}
		|-> !POWER_CTL.power_stage_en && !POWER_CTL.monitor_active && POWER_CTL.lin_wake_only)
		else $error("low power outputs wrong");
	a_startup_off: assert property (
		MODE inside {pmw_pkg::MODE_RESET, pmw_pkg::MODE_NORM_REQ}
		|-> !POWER_CTL.power_stage_en && !POWER_CTL.lin_enable)
		else $error("stages on during startup");
	a_stop_entry: assert property (
		$changed(MODE) && MODE == pmw_pkg::MODE_STOP
		|-> $past(MODE) == pmw_pkg::MODE_NORMAL && $past(STOP_REQ, 2) && !$past(SLEEP_REQ, 2))
		else $error("stop entered without request");
	a_sleep_entry: assert property (
		$changed(MODE) && MODE == pmw_pkg::MODE_SLEEP
		|-> ($past(MODE) == pmw_pkg::MODE_NORMAL && $past(SLEEP_REQ, 2))
		|| ($past(MODE) == pmw_pkg::MODE_NORM_REQ && !$past(FACTORY_TEST_STRAP, 2)))
		else $error("sleep entered without cause");
	a_stop_wake: assert property ($changed(MODE) && $past(MODE) == pmw_pkg::MODE_STOP |-> s_wake)
		else $error("stop left without enabled wake");
	a_clear_held: assert property (
		FLAG_CLR_WR && FLAG_CLR_DATA.overtemp && COND.overtemp && FLAGS.overtemp
		|=> FLAGS.overtemp)
		else $error("flag cleared while condition held");
	a_flag_wlc: assert property (
		FLAG_CLR_WR && FLAG_CLR_DATA.stage_fail && !COND.stage_fail && !$past(COND.stage_fail)
		|=> !FLAGS.stage_fail)
		else $error("flag not cleared");
	a_pulse_cause: assert property ($fell(EVENT_REQUEST_N) |-> $past(pend))
		else $error("event pulse without enabled flag");
	a_pulse_len: assert property ($fell(EVENT_REQUEST_N) |-> s_low8)
		else $error("event pulse too short");
endmodule : pmw_chk
bind power_mode_wake_irq_ctrl pmw_chk pmw_chk_i (.*);
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk, rst, stop_req, sleep_req, ack, strap, clr_wr, mask_wr, rs_clr, wake_in, lin_rx;
	logic wake_lvl, hall_lvl, hall_cap, int_rst, ack_en, reset_n, irq_n, wwf, bwf;
	pmw_pkg::irq_vec_t clr_data, mask_data, flags, mask;
	pmw_pkg::cond_t cond;
	pmw_pkg::mode_t mode;
	pmw_pkg::power_ctl_t pctl;
	int err_total, total_checks, cyc, pulses, p;
	int fb[4] = '{0, 3, 1, 2};
	power_mode_wake_irq_ctrl #(.TICK_CYCLES(2), .MONITOR_TICKS(5), .RESET_HOLD_CYCLES(8), .DOMINANT_CYCLES(4))
	power_mode_wake_irq_ctrl_i (.CORE_CLK(clk), .RST(rst), .STOP_REQ(stop_req), .SLEEP_REQ(sleep_req),
		.POWER_STAGE_ON_ACK(ack), .FACTORY_TEST_STRAP(strap), .FLAG_CLR_WR(clr_wr), .FLAG_CLR_DATA(clr_data),
		.MASK_WR(mask_wr), .MASK_DATA(mask_data), .RST_STATUS_CLR(rs_clr), .WAKE_INPUT(wake_in), .LIN_RX(lin_rx),
		.WAKE_LEVEL_FLAG(wake_lvl), .HALL_LEVEL_FLAG(hall_lvl), .HALL_IRQ_CAPABLE(hall_cap), .COND(cond),
		.INT_RESET_EVENT(int_rst), .RESET_LINE_N(reset_n), .EVENT_REQUEST_N(irq_n), .MODE(mode), .POWER_CTL(pctl),
		.FLAGS(flags), .MASK(mask), .WAKE_INPUT_WAKE_FLAG(wwf), .BUS_WAKE_RESET_FLAG(bwf));
	mcu_model mcu_model_i (.clk(clk), .reset_n(reset_n), .irq_n(irq_n), .ack_en(ack_en), .ack(ack), .pulses(pulses));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			test_done();
		end
	end
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task automatic wait_mode(input pmw_pkg::mode_t m);
		int i;
		for (i = 0; i < 400 && mode !== m; i++) tick(1);
		check("mode", {5'h00, mode}, {5'h00, m});
	endtask : wait_mode
	task automatic clear(input logic [7:0] d);
		clr_data = d;
		clr_wr = 1'b1;
		tick(1);
		clr_wr = 1'b0;
		tick(1);
	endtask : clear
	task automatic set_mask(input logic [7:0] d);
		mask_data = d;
		mask_wr = 1'b1;
		tick(1);
		mask_wr = 1'b0;
		tick(1);
	endtask : set_mask
	task automatic do_reset();
		rst = 1'b1;
		tick(5);
		rst = 1'b0;
	endtask : do_reset
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : test_done
	initial begin
		{rst, stop_req, sleep_req, strap, clr_wr, mask_wr, rs_clr, wake_in} = 8'h00;
		{wake_lvl, hall_lvl, hall_cap, int_rst, ack_en} = 5'h00;
		{clr_data, mask_data, cond} = 20'h00000;
		lin_rx = 1'b1;
		do_reset();
		tick(4);
		check("reset line", reset_n, 1'b0);
		check("flags", flags, 8'h00);
		check("mask", mask, 8'h00);
		wait_mode(pmw_pkg::MODE_NORM_REQ);
		check("reset line", reset_n, 1'b1);
		check("monitor", pctl.monitor_active, 1'b1);
		wait_mode(pmw_pkg::MODE_SLEEP);
		check("regulator", pctl.regulator_on, 1'b0);
		wake_in = 1'b1;
		wait_mode(pmw_pkg::MODE_RESET);
		check("input wake flag", wwf, 1'b1);
		ack_en = 1'b1;
		wait_mode(pmw_pkg::MODE_NORMAL);
		check("bus enable", pctl.lin_enable, 1'b1);
		set_mask(8'hFF);
		check("mask", mask, 8'hEF);
		for (int k = 0; k < 4; k++) begin
			p = pulses;
			cond[k] = 1'b1;
			tick(3);
			check("flag set", flags[fb[k]], 1'b1);
			check("pulses", 8'(pulses - p), 8'h01);
			clear(8'h01 << fb[k]);
			check("flag held", flags[fb[k]], 1'b1);
			cond[k] = 1'b0;
			tick(1);
			clear(8'h01 << fb[k]);
			check("flag clear", flags[fb[k]], 1'b0);
			tick(25);
		end
		hall_cap = 1'b1;
		hall_lvl = 1'b1;
		wake_lvl = 1'b1;
		tick(3);
		check("flags", flags, 8'hC0);
		clear(8'hC0);
		set_mask(8'h00);
		tick(25);
		p = pulses;
		hall_cap = 1'b0;
		hall_lvl = 1'b0;
		wake_lvl = 1'b0;
		tick(3);
		check("flags", flags, 8'h80);
		check("pulses", 8'(pulses - p), 8'h00);
		clear(8'h80);
		cond[1] = 1'b1;
		set_mask(8'h20);
		stop_req = 1'b1;
		tick(1);
		stop_req = 1'b0;
		wait_mode(pmw_pkg::MODE_STOP);
		check("stages", pctl.power_stage_en, 1'b0);
		check("limited", pctl.regulator_limited, 1'b1);
		clear(8'h08);
		check("flag held", flags.overtemp, 1'b1);
		cond[1] = 1'b0;
		clear(8'h08);
		check("flag clear", flags.overtemp, 1'b0);
		wake_in = 1'b0;
		tick(4);
		check("mode", mode, pmw_pkg::MODE_STOP);
		lin_rx = 1'b0;
		tick(6);
		lin_rx = 1'b1;
		wait_mode(pmw_pkg::MODE_NORMAL);
		check("flags", flags, 8'h20);
		clear(8'h20);
		sleep_req = 1'b1;
		stop_req = 1'b1;
		tick(1);
		{sleep_req, stop_req} = 2'b00;
		wait_mode(pmw_pkg::MODE_SLEEP);
		lin_rx = 1'b0;
		tick(6);
		lin_rx = 1'b1;
		wait_mode(pmw_pkg::MODE_RESET);
		check("bus wake flag", bwf, 1'b1);
		rs_clr = 1'b1;
		tick(1);
		rs_clr = 1'b0;
		tick(1);
		check("wake flags", {wwf, bwf}, 2'b00);
		strap = 1'b1;
		ack_en = 1'b0;
		do_reset();
		wait_mode(pmw_pkg::MODE_NORM_REQ);
		tick(60);
		check("mode", mode, pmw_pkg::MODE_NORM_REQ);
		check("monitor", pctl.monitor_active, 1'b0);
		int_rst = 1'b1;
		tick(2);
		int_rst = 1'b0;
		tick(5);
		check("reset line", reset_n, 1'b0);
		wait_mode(pmw_pkg::MODE_NORM_REQ);
		test_done();
	end
endmodule : tb_top
`default_nettype wire
